// ===== dsw_field.sv
/*
  Field side of the two pins: drives a level onto each undriven pin.
  Assumes the device output enable is low while the device drives.
*/
`timescale 1ns/1ns
module dsw_field (
  // Device side
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe_n,
  // Bench control
  input  wire logic [1:0] field_lvl,
  // Resolved levels
  output logic      [1:0] pin_in
);
  // Wire level from whichever party drives
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_in[i] = pin_oe_n[i] ? field_lvl[i] : pin_out[i];
    end
  end
endmodule

// ===== dsw_gpio.sv
/*
  Two-pin digital I/O with edge-selected secondary inputs and a watchdog.
  Assumes a single-cycle register port on clk, ADC base ticks as one-cycle
  pulses on clk, and asynchronous field levels on the pins.
*/
`timescale 1ns/1ns
module dsw_gpio (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  // Field pins
  input  wire logic [1:0]  pin_in,
  output logic      [1:0]  pin_out,
  output logic      [1:0]  pin_oe_n,
  // Board side
  input  wire logic        adc_tick,
  output logic             dac_load,
  output logic             adc_start,
  output logic             adc_trig,
  output logic             board_rst_req,
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]  pin_s1_r;
  logic [1:0]  pin_s2_r;
  logic [1:0]  pin_s3_r;
  logic [31:0] ctrl_r;
  logic [1:0]  data_r;
  logic [31:0] wd_cnt_r;
  logic        bark_r;
  logic        wd_flag_r;
  logic        hold_r;
  logic [4:0]  st_r;
  logic [4:0]  ie_r;
  logic [4:0]  hit;
  logic        soft_rst;
  logic        expire;
  logic        wr_irq;
  logic        wr_data;
  logic        wr_ctrl;
  logic        wr_wdog;
  logic [31:0] rdata_nxt;
  // Edge test selected by the edge bit
  function automatic logic edge_hit(input logic cur, input logic prev, input logic rising);
    edge_hit = rising ? (cur & ~prev) : (~cur & prev);
  endfunction

  // ----------------------------------------------------------------
  // Decode and board reset
  // ----------------------------------------------------------------
  assign wr_irq   = reg_wr && (reg_addr == dsw_pkg::OFS_IRQ);
  assign wr_data  = reg_wr && (reg_addr == dsw_pkg::OFS_DATA);
  assign wr_ctrl  = reg_wr && (reg_addr == dsw_pkg::OFS_CTRL);
  assign wr_wdog  = reg_wr && (reg_addr == dsw_pkg::OFS_WDOG);
  assign soft_rst = sys_rst | bark_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // two stages then history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  // Function control, direction bits
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      ctrl_r <= dsw_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata & dsw_pkg::CTRL_MASK;
    end
  end

  // Output data
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      data_r <= 2'h0;
    end else if (wr_data) begin
      data_r <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Secondary input functions
  // ----------------------------------------------------------------
  for (genvar g = 0; g < dsw_pkg::NFUNC; g++) begin : g_func
    assign hit[g] = ctrl_r[dsw_pkg::EN_POS[g]]
                  & edge_hit(pin_s2_r[dsw_pkg::PIN_OF[g]], pin_s3_r[dsw_pkg::PIN_OF[g]],
                             ctrl_r[dsw_pkg::EDGE_POS[g]]);

    always_ff @(posedge clk) begin
      if (soft_rst) begin
        st_r[g] <= 1'b0;
      end else begin
        st_r[g] <= (st_r[g] & ~(wr_irq & reg_wdata[dsw_pkg::ST_BIT[g]])) | (hit[g] & ie_r[g]);
      end
    end

    always_ff @(posedge clk) begin
      if (soft_rst) begin
        ie_r[g] <= 1'b0;
      end else if (wr_irq) begin
        ie_r[g] <= reg_wdata[dsw_pkg::IE_BIT[g]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_load  <= 1'b0;
      adc_start <= 1'b0;
      adc_trig  <= 1'b0;
    end else begin
      dac_load  <= hit[dsw_pkg::FN_LOAD];
      adc_start <= hit[dsw_pkg::FN_START];
      adc_trig  <= hit[dsw_pkg::FN_TRIG];
    end
  end

  // Level request to the interrupt controller
  assign irq_out = |(st_r & ie_r);

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // last tick expires
  assign expire = adc_tick && !wr_wdog && (wd_cnt_r == dsw_pkg::WDOG_LAST);

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      wd_cnt_r <= dsw_pkg::WDOG_RST;
    end else if (wr_wdog) begin
      wd_cnt_r <= reg_wdata;
    end else if (adc_tick && (wd_cnt_r != dsw_pkg::WDOG_RST)) begin
      wd_cnt_r <= wd_cnt_r - dsw_pkg::WDOG_LAST;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bark_r <= 1'b0;
    end else begin
      bark_r <= expire;
    end
  end
  assign board_rst_req = bark_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_flag_r <= 1'b0;
    end else begin
      wd_flag_r <= (wd_flag_r & ~(wr_irq & reg_wdata[dsw_pkg::WDOG_FLAG_POS])) | bark_r;
    end
  end

  // keep pin 1 low after expiry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_r <= 1'b0;
    end else if (expire && ctrl_r[dsw_pkg::WDOG_OUT_POS]) begin
      hold_r <= 1'b1;
    end else if (wr_ctrl) begin
      hold_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // direction and level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_oe_n <= 2'h3;
      pin_out  <= 2'h0;
    end else begin
      pin_oe_n[0] <= ~ctrl_r[dsw_pkg::DIR0_POS];
      pin_out[0]  <= data_r[0];
      pin_oe_n[1] <= ~(ctrl_r[dsw_pkg::DIR1_POS] | ctrl_r[dsw_pkg::WDOG_OUT_POS] | hold_r);
      pin_out[1]  <= hold_r ? 1'b0 : (ctrl_r[dsw_pkg::WDOG_OUT_POS] | data_r[1]);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux, unmapped reads zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      dsw_pkg::OFS_IRQ: begin
        rdata_nxt[dsw_pkg::WDOG_FLAG_POS] = wd_flag_r;
        for (int i = 0; i < dsw_pkg::NFUNC; i++) begin
          rdata_nxt[dsw_pkg::ST_BIT[i]] = st_r[i];
          rdata_nxt[dsw_pkg::IE_BIT[i]] = ie_r[i];
        end
      end
      dsw_pkg::OFS_DATA: begin
        for (int i = 0; i < 2; i++) begin
          rdata_nxt[i] = ctrl_r[dsw_pkg::DIR0_POS + i] ? data_r[i] : pin_s2_r[i];
        end
      end
      dsw_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
      dsw_pkg::OFS_WDOG: rdata_nxt = wd_cnt_r;
      default:           rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Registered read answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rdata_nxt : 32'h0000_0000;
      reg_rvalid <= reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_bark_with_out;
    expire && ctrl_r[dsw_pkg::WDOG_OUT_POS];
  endsequence
  sequence s_pin1_low;
    !pin_oe_n[1] && !pin_out[1];
  endsequence
  chk_wdog_pin_on: assert property (ctrl_r[dsw_pkg::WDOG_OUT_POS] && !hold_r
    |=> !pin_oe_n[1] && pin_out[1]) else $error("pin 1 not showing watchdog state");
  chk_ext_irq_latch: assert property (hit[dsw_pkg::FN_EXT0] && ie_r[dsw_pkg::FN_EXT0]
    && !bark_r |=> st_r[dsw_pkg::FN_EXT0]) else $error("external irq 0 not latched");
  chk_dac_load_pulse: assert property (hit[dsw_pkg::FN_LOAD] |=> dac_load)
    else $error("dac load pulse missing");
  chk_fall_start: assert property (ctrl_r[dsw_pkg::EN_POS[dsw_pkg::FN_START]]
    && !ctrl_r[dsw_pkg::EDGE_POS[dsw_pkg::FN_START]] && $fell(pin_s2_r[0]) |=> adc_start)
    else $error("falling edge start missed");
  chk_adc_trig_pulse: assert property (hit[dsw_pkg::FN_TRIG] |=> adc_trig)
    else $error("adc trigger pulse missing");
  chk_dir_oe_map: assert property (1'b1 |=>
    pin_oe_n[0] == !$past(ctrl_r[dsw_pkg::DIR0_POS])) else $error("pin 0 direction wrong");
  chk_data_drive: assert property (ctrl_r[dsw_pkg::DIR0_POS]
    |=> pin_out[0] == $past(data_r[0])) else $error("pin 0 level wrong");
  chk_bark_hold_low: assert property (s_bark_with_out |=> !pin_oe_n[1] ##1 s_pin1_low)
    else $error("pin 1 not held low after expiry");
  chk_bark_flag_set: assert property (expire |=> board_rst_req ##1 wd_flag_r)
    else $error("watchdog flag not latched");
  chk_wdog_zero_off: assert property (wr_wdog && reg_wdata == 32'h0000_0000
    |=> !board_rst_req [*3]) else $error("disabled watchdog expired");
  chk_single_pulse: assert property (adc_start |=> !adc_start)
    else $error("start pulse longer than one cycle");
endmodule

// ===== dsw_gpio_tb.sv
/*
  Self-checking bench for the two-pin I/O block.
  Assumes the field model resolves the pins and ticks come from the bench.
*/
`timescale 1ns/1ns
module dsw_gpio_tb;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic [1:0]  pin_in;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe_n;
  logic [1:0]  field_lvl;
  logic        adc_tick;
  logic        dac_load;
  logic        adc_start;
  logic        adc_trig;
  logic        board_rst_req;
  logic        irq_out;
  int          n_fail;
  int          checked;
  int          n_ev [3];
  int          n_rst;
  int          n0;
  int          p;

  dsw_gpio dsw_gpio_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .adc_tick(adc_tick),
    .dac_load(dac_load), .adc_start(adc_start), .adc_trig(adc_trig),
    .board_rst_req(board_rst_req), .irq_out(irq_out));
  dsw_field dsw_field_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .field_lvl(field_lvl),
    .pin_in(pin_in));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulse counters
  always @(posedge clk) begin
    if (adc_trig === 1'b1) n_ev[0]++;
    if (adc_start === 1'b1) n_ev[1]++;
    if (dac_load === 1'b1) n_ev[2]++;
    if (board_rst_req === 1'b1) n_rst++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      adc_tick <= 1'b1;
      @(posedge clk);
      adc_tick <= 1'b0;
    end
  endtask

  // Watchdog on a hang
  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h0000_0000;
    field_lvl = 2'b00;
    adc_tick  = 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(dsw_pkg::OFS_CTRL, dsw_pkg::CTRL_RST);
    rd_chk(dsw_pkg::OFS_WDOG, dsw_pkg::WDOG_RST);
    chk({30'h0, pin_oe_n}, 32'h3);
    $display("test reset done");
    // Direction and data
    wr(dsw_pkg::OFS_CTRL, 32'h3);
    wr(dsw_pkg::OFS_DATA, 32'h1);
    wt(2);
    chk({30'h0, pin_oe_n}, 32'h0);
    chk({30'h0, pin_out}, 32'h1);
    @(posedge clk);
    field_lvl <= 2'b10;
    wr(dsw_pkg::OFS_CTRL, 32'h1);
    wt(5);
    rd_chk(dsw_pkg::OFS_DATA, 32'h3);
    $display("test pins done");
    // Every function on both edges
    for (int f = 0; f < dsw_pkg::NFUNC; f++) begin
      for (int e = 0; e < 2; e++) begin
        p = dsw_pkg::PIN_OF[f];
        @(posedge clk);
        field_lvl[p] <= ~e[0];
        wr(dsw_pkg::OFS_CTRL, (1 << dsw_pkg::EN_POS[f]) | (e << dsw_pkg::EDGE_POS[f]));
        wt(6);
        wr(dsw_pkg::OFS_IRQ, 32'h01c3_0000 | (1 << dsw_pkg::IE_BIT[f]));
        n0 = (f < 3) ? n_ev[f] : 0;
        @(posedge clk);
        field_lvl[p] <= e[0];
        repeat (8) @(posedge clk);
        field_lvl[p] <= ~e[0];
        wt(8);
        rd_chk(dsw_pkg::OFS_IRQ, (1 << dsw_pkg::ST_BIT[f]) | (1 << dsw_pkg::IE_BIT[f]));
        chk({31'h0, irq_out}, 32'h1);
        if (f < 3) chk(n_ev[f] - n0, 32'h1);
        wr(dsw_pkg::OFS_IRQ, 1 << dsw_pkg::ST_BIT[f]);
        rd_chk(dsw_pkg::OFS_IRQ, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
      end
    end
    $display("test functions done");
    // Watchdog status, restart, expiry, disable
    wr(dsw_pkg::OFS_CTRL, 1 << dsw_pkg::WDOG_OUT_POS);
    wt(2);
    chk({31'h0, pin_oe_n[1]}, 32'h0);
    chk({31'h0, pin_out[1]}, 32'h1);
    wr(dsw_pkg::OFS_WDOG, 32'h3);
    tick(1);
    rd_chk(dsw_pkg::OFS_WDOG, 32'h2);
    tick(1);
    wr(dsw_pkg::OFS_WDOG, 32'h3);
    tick(2);
    wt(3);
    chk(n_rst, 32'h0);
    tick(1);
    wt(3);
    chk(n_rst, 32'h1);
    rd_chk(dsw_pkg::OFS_IRQ, 32'h8000_0000);
    rd_chk(dsw_pkg::OFS_CTRL, 32'h0);
    chk({30'h0, pin_oe_n[1], pin_out[1]}, 32'h0);
    wr(dsw_pkg::OFS_IRQ, 32'h8000_0000);
    rd_chk(dsw_pkg::OFS_IRQ, 32'h0);
    wr(dsw_pkg::OFS_WDOG, 32'h2);
    tick(1);
    wr(dsw_pkg::OFS_WDOG, 32'h0);
    rd_chk(dsw_pkg::OFS_WDOG, 32'h0);
    tick(6);
    wt(3);
    chk(n_rst, 32'h1);
    $display("test watchdog done");
    summarize();
  end
endmodule

// ===== dsw_pkg.sv
/*
  Constants for the two-pin I/O block: register offsets, field positions
  and reset values.
  Assumes a 32-bit register port with byte addresses in the low eight bits.
*/
package dsw_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_IRQ  = 8'h40;
  localparam logic [7:0]  OFS_DATA = 8'h44;
  localparam logic [7:0]  OFS_CTRL = 8'h48;
  localparam logic [7:0]  OFS_WDOG = 8'h4c;

  // ----------------------------------------------------------------
  // Pin function control fields
  // ----------------------------------------------------------------
  localparam int          DIR0_POS       = 0;
  localparam int          DIR1_POS       = 1;
  localparam int          WDOG_OUT_POS   = 26;
  localparam logic [31:0] CTRL_MASK      = 32'h07ff_0003;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  // Secondary functions, index 0..4: trigger, start, dac load, irq0, irq1
  localparam int          NFUNC          = 5;
  localparam int          FN_TRIG        = 0;
  localparam int          FN_START       = 1;
  localparam int          FN_LOAD        = 2;
  localparam int          FN_EXT0        = 3;
  localparam int          FN_EXT1        = 4;
  localparam int          EN_POS   [5]   = '{16, 18, 20, 22, 24};
  localparam int          EDGE_POS [5]   = '{17, 19, 21, 23, 25};
  localparam int          PIN_OF   [5]   = '{0, 0, 1, 0, 1};

  // ----------------------------------------------------------------
  // Interrupt status and enable fields
  // ----------------------------------------------------------------
  localparam int          ST_BIT   [5]   = '{16, 17, 22, 23, 24};
  localparam int          IE_BIT   [5]   = '{0, 1, 6, 7, 8};
  localparam int          WDOG_FLAG_POS  = 31;

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  localparam logic [31:0] WDOG_RST       = 32'h0000_0000;
  localparam logic [31:0] WDOG_LAST      = 32'h0000_0001;
endpackage
